// ===== verilog/bpi_ctrl.sv
// Overview of operation
// RULE1 - 128-entry direct map, index VA bits 9:3
// RULE2 - entries are two-bit saturating counters
// RULE3 - predict constant offsets only, never register
// RULE4 - dynamic hit costs one, folded costs zero
// RULE5 - dynamic miss uses static predict, four cycles
// RULE6 - three-entry return stack predicts from issue
// RULE7 - only unconditional returns predicted, empty none
// RULE8 - push on link branches and exchanges
// RULE9 - pop on the four return forms
// RULE10 - mismatched popped address means mispredict
// RULE11 - correct return prediction costs four cycles
// RULE12 - three parallel four-stage execution pipes
// RULE13 - alu/mult lock-step; load/store decoupled
// RULE14 - forward alu, sat, writebacks; accumulate path (fwd_sel_reg offers no accumulate source)
// RULE15 - stall dependent until producer latency elapses
// RULE16 - early operand adds one latency cycle
// RULE17 - late operand subtracts one latency cycle
// RULE18 - store sources write-locked, overwriters held
// RULE19 - failing one/two cycle instrs keep cost
// RULE20 - failing multicycle: min(pass,max(5-dist,3))
// RULE21 - flag distance counts cycles incl interlocks
// RULE22 - same-register writes ordered; opposite conds free
//
// Purpose: instruction-flow prediction and hazard interlock control for one core
// Assumes: decoder presents fetch, producer and consumer descriptors each cycle
// Notes:   execution stage datapaths are outside; this block steers them
`timescale 1ns/100ps
module bpi_ctrl
	import bpi_pkg::*;
#(
	parameter int ENTRIES  = BPI_TABLE_ENTRIES,
	parameter int RS_DEPTH = BPI_RS_DEPTH
) (
	input  wire logic          sys_clk,
	input  wire logic          resetn,
	input  wire bpi_fetch_type fetch,
	input  wire logic          resolve_valid,
	input  wire logic [31:0]   resolve_va,
	input  wire logic          resolve_taken,
	input  wire logic          ret_resolve,
	input  wire logic [31:0]   ret_actual,
	input  wire bpi_prod_type  prod,
	input  wire bpi_cons_type  cons,
	input  wire logic          cons_cond_fail,
	input  wire logic          cons_multicycle,
	input  wire logic [3:0]    passing_cycle_count,
	input  wire logic [3:0]    base_cycles,
	input  wire logic          flag_set,
	input  wire logic          ls_busy,
	output logic               predict_valid,
	output logic               predict_taken,
	output logic [31:0]        predict_target,
	output logic               predict_from_issue,
	output logic [3:0]         branch_cost_reg,
	output logic               ret_mispredict_reg,
	output logic               stall,
	output logic [3:0]         issue_cycles_reg,
	output logic [3:0]         flag_to_use_distance,
	output logic [2:0]         fwd_sel_reg,
	output logic               alu_advance,
	output logic               ls_advance
);

	localparam int IDXW = BPI_IDX_MSB - BPI_IDX_LSB + 1;

	// ----------------------------------------------------------------
	// elaboration checks
	// ----------------------------------------------------------------
	if (ENTRIES != (1 << IDXW)) begin : g_chk_entries
		$error("ENTRIES must match the index width");
	end
	if (RS_DEPTH < 1 || RS_DEPTH > 7) begin : g_chk_rs
		$error("RS_DEPTH out of range");
	end

	// ----------------------------------------------------------------
	// dynamic predictor table
	// ----------------------------------------------------------------
	bpi_ctr_type        ctr_reg [ENTRIES];
	logic               tag_ok_reg [ENTRIES];
	logic [IDXW-1:0]    fidx;
	logic [IDXW-1:0]    ridx;
	logic               is_const;
	logic               dyn_hit;

	assign fidx     = fetch.va[BPI_IDX_MSB:BPI_IDX_LSB]; // RULE1
	assign ridx     = resolve_va[BPI_IDX_MSB:BPI_IDX_LSB];
	assign is_const = fetch.kind == BPI_BR_IMM || fetch.kind == BPI_BR_LINK_IMM
		|| fetch.kind == BPI_BLX_IMM; // RULE3
	assign dyn_hit  = fetch.valid && is_const && tag_ok_reg[fidx];

	// counters saturate at both ends; untouched entries count as a table miss
	genvar gi;
	generate
		for (gi = 0; gi < ENTRIES; gi++) begin : g_ctr
			always_ff @(posedge sys_clk or negedge resetn) begin
				if (!resetn) begin
					ctr_reg[gi]    <= bpi_ctr_type'(BPI_CTR_RESET);
					tag_ok_reg[gi] <= 1'b0;
				end else if (resolve_valid && ridx == IDXW'(gi)) begin
					tag_ok_reg[gi] <= 1'b1;
					if (resolve_taken && ctr_reg[gi] != BPI_STRONG_T) begin
						ctr_reg[gi] <= bpi_ctr_type'(ctr_reg[gi] + 2'h1); // RULE2
					end else if (!resolve_taken && ctr_reg[gi] != BPI_STRONG_NT) begin
						ctr_reg[gi] <= bpi_ctr_type'(ctr_reg[gi] - 2'h1); // RULE2
					end
				end
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// return stack
	// ----------------------------------------------------------------
	logic [31:0] rs_reg [RS_DEPTH];
	logic [2:0]  rs_cnt_reg;
	logic        is_push;
	logic        is_pop;
	logic        ret_predict;
	logic [31:0] ret_addr_reg;
	logic        ret_pend_reg;

	assign is_push = fetch.valid && (fetch.kind == BPI_BR_LINK_IMM
		|| fetch.kind == BPI_BLX_IMM || fetch.kind == BPI_BLX_REG); // RULE8
	assign is_pop  = fetch.valid && (fetch.kind == BPI_RET_BX_LR
		|| fetch.kind == BPI_RET_MOV_LR || fetch.kind == BPI_RET_LDR_SP
		|| fetch.kind == BPI_RET_LDM_SP); // RULE9
	assign ret_predict = is_pop && !fetch.cond && rs_cnt_reg != 3'h0; // RULE7

	// push shifts entries down, oldest falls off when full
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			rs_cnt_reg <= 3'h0;
			for (int i = 0; i < RS_DEPTH; i++) begin
				rs_reg[i] <= 32'h0;
			end
		end else if (is_push) begin
			rs_reg[0] <= fetch.link_addr; // RULE8
			for (int i = 1; i < RS_DEPTH; i++) begin
				rs_reg[i] <= rs_reg[i-1];
			end
			if (rs_cnt_reg != 3'(RS_DEPTH)) begin
				rs_cnt_reg <= rs_cnt_reg + 3'h1;
			end
		end else if (is_pop && rs_cnt_reg != 3'h0) begin
			for (int i = 0; i < RS_DEPTH - 1; i++) begin
				rs_reg[i] <= rs_reg[i+1]; // RULE7
			end
			rs_cnt_reg <= rs_cnt_reg - 3'h1; // RULE9
		end
	end

	// remember the predicted address until the return resolves
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			ret_addr_reg       <= 32'h0;
			ret_pend_reg       <= 1'b0;
			ret_mispredict_reg <= 1'b0;
		end else begin
			ret_mispredict_reg <= 1'b0;
			if (ret_predict) begin
				ret_addr_reg <= rs_reg[0];
				ret_pend_reg <= 1'b1;
			end else if (ret_resolve) begin
				ret_pend_reg <= 1'b0;
			end
			if (ret_resolve && ret_pend_reg) begin
				ret_mispredict_reg <= ret_actual != ret_addr_reg; // RULE10
			end
		end
	end

	// ----------------------------------------------------------------
	// prediction outputs and branch cost
	// ----------------------------------------------------------------
	always_comb begin
		predict_valid      = 1'b0;
		predict_taken      = 1'b0;
		predict_target     = 32'h0;
		predict_from_issue = 1'b0;
		if (ret_predict) begin
			predict_valid      = 1'b1; // RULE6
			predict_taken      = 1'b1;
			predict_target     = rs_reg[0];
			predict_from_issue = 1'b1; // RULE6
		end else if (dyn_hit) begin
			predict_valid = 1'b1;
			predict_taken = ctr_reg[fidx] == BPI_WEAK_T || ctr_reg[fidx] == BPI_STRONG_T;
		end else if (fetch.valid && is_const) begin
			predict_valid      = 1'b1; // RULE5
			predict_taken      = 1'b1; // unconditional static guess
			predict_from_issue = 1'b1; // RULE5
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			branch_cost_reg <= 4'h0;
		end else if (ret_predict) begin
			branch_cost_reg <= BPI_COST_RET_OK; // RULE11
		end else if (dyn_hit) begin
			branch_cost_reg <= fetch.in_pfb ? BPI_COST_FOLD : BPI_COST_DYN; // RULE4
		end else if (fetch.valid && is_const) begin
			branch_cost_reg <= BPI_COST_STATIC; // RULE5
		end
	end

	// ----------------------------------------------------------------
	// register scoreboard: latency countdown and store write locks
	// ----------------------------------------------------------------
	logic [3:0]  ready_cnt_reg [BPI_NREGS];
	logic [3:0]  lock_cnt_reg  [BPI_NREGS];
	logic [3:0]  wcond_reg     [BPI_NREGS];
	logic [3:0]  need;
	logic        raw_stall;
	logic        waw_stall;
	logic        lock_stall;
	logic        opposite;

	// producer latency counts from its first cycle; a stall freezes nothing here
	generate
		for (gi = 0; gi < BPI_NREGS; gi++) begin : g_sb
			always_ff @(posedge sys_clk or negedge resetn) begin
				if (!resetn) begin
					ready_cnt_reg[gi] <= 4'h0;
					wcond_reg[gi]     <= 4'h0;
				end else if (prod.valid && prod.wr && prod.dst == 4'(gi)) begin
					ready_cnt_reg[gi] <= prod.latency; // RULE15
					wcond_reg[gi]     <= prod.cond_code;
				end else if (ready_cnt_reg[gi] != 4'h0) begin
					ready_cnt_reg[gi] <= ready_cnt_reg[gi] - 4'h1; // RULE15
				end
			end
			always_ff @(posedge sys_clk or negedge resetn) begin
				if (!resetn) begin
					lock_cnt_reg[gi] <= 4'h0;
				end else if (prod.valid && prod.store_lock && prod.lock_mask[gi]) begin
					lock_cnt_reg[gi] <= prod.lock_cycles; // RULE18
				end else if (lock_cnt_reg[gi] != 4'h0) begin
					lock_cnt_reg[gi] <= lock_cnt_reg[gi] - 4'h1;
				end
			end
		end
	endgenerate

	// remaining latency adjusted for when the consumer needs its operand
	always_comb begin
		need = ready_cnt_reg[cons.src];
		if (cons.early) begin
			need = need + BPI_EARLY_ADD; // RULE16
		end else if (cons.late && need != 4'h0) begin
			need = need - BPI_LATE_SUB; // RULE17
		end
	end

	// condition codes pair by flipping the low bit
	assign opposite   = (cons.cond_code ^ wcond_reg[cons.dst]) == 4'h1;
	assign raw_stall  = cons.valid && cons.src_used && need > 4'h1; // RULE15
	assign waw_stall  = cons.valid && cons.wr && ready_cnt_reg[cons.dst] > 4'h1
		&& !(opposite && !cons.reads_dst); // RULE22
	assign lock_stall = cons.valid && cons.wr && lock_cnt_reg[cons.dst] != 4'h0; // RULE18
	assign stall      = raw_stall || waw_stall || lock_stall;

	// ----------------------------------------------------------------
	// pipe advance and forwarding source
	// ----------------------------------------------------------------
	// alu and multiply share one advance; load/store runs on its own busy
	assign alu_advance = !stall; // RULE13
	assign ls_advance  = !ls_busy; // RULE13

	// 0 none, 1 arith, 2 saturate, 3 exec writeback, 4 load/store writeback
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			fwd_sel_reg <= 3'h0;
		end else if (cons.valid && cons.src_used && !stall) begin
			case (ready_cnt_reg[cons.src])
				4'h0:    fwd_sel_reg <= 3'h3; // RULE14
				4'h1:    fwd_sel_reg <= 3'h1; // RULE14
				4'h2:    fwd_sel_reg <= 3'h2; // RULE14
				default: fwd_sel_reg <= 3'h4; // RULE12
			endcase
		end else begin
			fwd_sel_reg <= 3'h0;
		end
	end

	// ----------------------------------------------------------------
	// flag distance and condition-fail issue cost
	// ----------------------------------------------------------------
	logic [3:0] fdist_reg;
	logic [3:0] fail_cost;

	// every cycle counts, stalled ones included, saturating
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			fdist_reg <= 4'h0;
		end else if (flag_set) begin
			fdist_reg <= 4'h0; // RULE21
		end else if (fdist_reg != 4'hf) begin
			fdist_reg <= fdist_reg + 4'h1; // RULE21
		end
	end
	assign flag_to_use_distance = fdist_reg;

	always_comb begin
		fail_cost = BPI_FAIL_FLOOR;
		if (fdist_reg < BPI_FAIL_BASE - BPI_FAIL_FLOOR) begin
			fail_cost = BPI_FAIL_BASE - fdist_reg; // RULE20
		end
		if (passing_cycle_count < fail_cost) begin
			fail_cost = passing_cycle_count; // RULE20
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			issue_cycles_reg <= 4'h0;
		end else if (cons.valid && !stall) begin
			if (cons_cond_fail && cons_multicycle) begin
				issue_cycles_reg <= fail_cost; // RULE20
			end else begin
				issue_cycles_reg <= base_cycles; // RULE19
			end
		end
	end

endmodule : bpi_ctrl

// ===== verilog/bpi_pkg.sv
// Purpose: shared constants and types for the branch predict / interlock control block
// Assumes: one core clock, decoded instruction attributes supplied by the decoder
// Notes:   cycle figures are best-case instruction-flow costs
package bpi_pkg;

	// ----------------------------------------------------------------
	// predictor geometry
	// ----------------------------------------------------------------
	localparam int BPI_TABLE_ENTRIES = 128;
	localparam int BPI_IDX_LSB       = 3;
	localparam int BPI_IDX_MSB       = 9;
	localparam int BPI_RS_DEPTH      = 3;
	localparam int BPI_NREGS         = 16;

	// ----------------------------------------------------------------
	// cycle costs
	// ----------------------------------------------------------------
	localparam logic [3:0] BPI_COST_DYN      = 4'h1;
	localparam logic [3:0] BPI_COST_FOLD     = 4'h0;
	localparam logic [3:0] BPI_COST_STATIC   = 4'h4;
	localparam logic [3:0] BPI_COST_RET_OK   = 4'h4;
	localparam logic [3:0] BPI_FAIL_BASE     = 4'h5;
	localparam logic [3:0] BPI_FAIL_FLOOR    = 4'h3;
	localparam logic [3:0] BPI_EARLY_ADD     = 4'h1;
	localparam logic [3:0] BPI_LATE_SUB      = 4'h1;
	localparam logic [1:0] BPI_CTR_RESET     = 2'h1;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		BPI_STRONG_NT,
		BPI_WEAK_NT,
		BPI_WEAK_T,
		BPI_STRONG_T
	} bpi_ctr_type;

	typedef enum logic [3:0] {
		BPI_BR_NONE,
		BPI_BR_IMM,              // constant-offset branch
		BPI_BR_REG,              // register-offset branch
		BPI_BR_LINK_IMM,         // branch_with_link immediate
		BPI_BLX_IMM,             // branch_link_exchange immediate
		BPI_BLX_REG,             // branch_link_exchange register
		BPI_RET_BX_LR,           // branch_exchange via link register
		BPI_RET_MOV_LR,          // move link register to pc
		BPI_RET_LDR_SP,          // post-indexed sp load to pc
		BPI_RET_LDM_SP           // load_multiple_increment from sp incl pc
	} bpi_brkind_type;

	typedef struct packed {
		logic           valid;
		bpi_brkind_type kind;
		logic           cond;     // conditional instruction
		logic           in_pfb;   // next instr arrived while branch in prefetch buffer
		logic [31:0]    va;
		logic [31:0]    link_addr;
	} bpi_fetch_type;

	typedef struct packed {
		logic        valid;
		logic [3:0]  dst;
		logic        wr;
		logic [3:0]  latency;     // result latency of producer
		logic [3:0]  cond_code;
		logic        store_lock;  // store_multiple / store_double source lock
		logic [15:0] lock_mask;
		logic [3:0]  lock_cycles;
	} bpi_prod_type;

	typedef struct packed {
		logic       valid;
		logic [3:0] src;
		logic       src_used;
		logic       early;        // needed at shift / mult1 / address start
		logic       late;         // needed in second issue cycle
		logic [3:0] dst;
		logic       wr;
		logic [3:0] cond_code;
		logic       reads_dst;    // a read of the common register intervenes
	} bpi_cons_type;

endpackage : bpi_pkg

// ===== verification/bpi_ctrl_checker.sv
// Purpose: port-level assertions for bpi_ctrl
// Assumes: one clock domain, asynchronous active-low reset
// Notes:   attached to every bpi_ctrl instance by the bind at the foot
`timescale 1ns/100ps
module bpi_ctrl_checker
	import bpi_pkg::*;
(
	input wire logic          sys_clk,
	input wire logic          resetn,
	input wire bpi_fetch_type fetch,
	input wire logic          ret_resolve,
	input wire bpi_prod_type  prod,
	input wire bpi_cons_type  cons,
	input wire logic          cons_cond_fail,
	input wire logic          cons_multicycle,
	input wire logic [3:0]    passing_cycle_count,
	input wire logic [3:0]    base_cycles,
	input wire logic          flag_set,
	input wire logic          ls_busy,
	input wire logic          predict_valid,
	input wire logic          predict_from_issue,
	input wire logic [3:0]    branch_cost_reg,
	input wire logic          ret_mispredict_reg,
	input wire logic          stall,
	input wire logic [3:0]    issue_cycles_reg,
	input wire logic [3:0]    flag_to_use_distance,
	input wire logic          alu_advance,
	input wire logic          ls_advance
);
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	logic is_ret;

	// any of the four pop forms
	assign is_ret = fetch.kind inside {BPI_RET_BX_LR, BPI_RET_MOV_LR, BPI_RET_LDR_SP, BPI_RET_LDM_SP};

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);

	sequence s_ret_pred;
		fetch.valid && is_ret && predict_valid;
	endsequence

	// latency-one producer followed at once by a shifter-stage reader
	sequence s_early_use;
		prod.valid && prod.wr && prod.latency == 4'h1 ##1
		cons.valid && cons.src_used && cons.early && !cons.late && cons.src == $past(prod.dst);
	endsequence

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	a_reg_never_pred: assert property (
		fetch.valid && fetch.kind == BPI_BR_REG |-> !predict_valid)
		else $error("register-offset branch was predicted");
	a_cond_ret_quiet: assert property (
		fetch.valid && is_ret && fetch.cond |-> !predict_valid)
		else $error("conditional return was predicted");
	a_static_cost: assert property (
		fetch.valid && fetch.kind == BPI_BR_IMM && predict_valid && predict_from_issue
		|=> branch_cost_reg == BPI_COST_STATIC)
		else $error("static branch cost wrong");
	a_dyn_cost: assert property (
		fetch.valid && fetch.kind == BPI_BR_IMM && predict_valid && !predict_from_issue
		|=> branch_cost_reg == ($past(fetch.in_pfb) ? BPI_COST_FOLD : BPI_COST_DYN))
		else $error("dynamic branch cost wrong");
	a_ret_issue_cost: assert property (
		s_ret_pred |-> predict_from_issue ##1 branch_cost_reg == BPI_COST_RET_OK)
		else $error("return prediction source or cost wrong");
	a_mispred_cause: assert property (
		ret_mispredict_reg |-> $past(ret_resolve))
		else $error("mispredict without a return resolve");
	a_alu_lockstep: assert property (
		alu_advance == !stall)
		else $error("alu advance disagrees with stall");
	a_ls_decoupled: assert property (
		ls_advance == !ls_busy)
		else $error("load/store advance not decoupled");
	a_fail_short: assert property (
		cons.valid && cons_cond_fail && !cons_multicycle && !stall
		|=> issue_cycles_reg == $past(base_cycles))
		else $error("failing short instruction cost wrong");
	a_fail_bounds: assert property (
		cons.valid && cons_cond_fail && cons_multicycle && !stall
		|=> issue_cycles_reg <= $past(passing_cycle_count) && issue_cycles_reg <= BPI_FAIL_BASE
		&& (issue_cycles_reg >= BPI_FAIL_FLOOR || issue_cycles_reg == $past(passing_cycle_count)))
		else $error("failing multicycle cost out of bounds");
	a_flag_restart: assert property (
		flag_set |=> flag_to_use_distance == 4'h0)
		else $error("flag distance not restarted");
	a_early_stall: assert property (
		s_early_use |-> stall)
		else $error("early operand did not stall");

endmodule : bpi_ctrl_checker

bind bpi_ctrl bpi_ctrl_checker i_bpi_ctrl_checker (
	.sys_clk(sys_clk), .resetn(resetn), .fetch(fetch), .ret_resolve(ret_resolve),
	.prod(prod), .cons(cons), .cons_cond_fail(cons_cond_fail),
	.cons_multicycle(cons_multicycle), .passing_cycle_count(passing_cycle_count),
	.base_cycles(base_cycles), .flag_set(flag_set), .ls_busy(ls_busy),
	.predict_valid(predict_valid), .predict_from_issue(predict_from_issue),
	.branch_cost_reg(branch_cost_reg), .ret_mispredict_reg(ret_mispredict_reg),
	.stall(stall), .issue_cycles_reg(issue_cycles_reg),
	.flag_to_use_distance(flag_to_use_distance), .alu_advance(alu_advance),
	.ls_advance(ls_advance)
);

// ===== verification/tb_top.sv
// Purpose: self-checking bench for bpi_ctrl
// Assumes: 100 MHz sys_clk, resetn held low three cycles
// Notes:   inputs move by non-blocking assignment on the rising edge, sampled at the falling
`timescale 1ns/100ps
module tb_top;
	import bpi_pkg::*;
	// ----------------------------------------------------------------
	// signals
	// ----------------------------------------------------------------
	logic          sys_clk, resetn, resolve_valid, resolve_taken, ret_resolve;
	logic          cons_cond_fail, cons_multicycle, flag_set, ls_busy;
	logic [31:0]   resolve_va, ret_actual, predict_target;
	logic [3:0]    passing_cycle_count, base_cycles;
	logic [3:0]    branch_cost_reg, issue_cycles_reg, flag_to_use_distance;
	logic [2:0]    fwd_sel_reg;
	logic          predict_valid, predict_taken, predict_from_issue, ret_mispredict_reg;
	logic          stall, alu_advance, ls_advance;
	bpi_fetch_type fetch;
	bpi_prod_type  prod;
	bpi_cons_type  cons;
	int            bad_count = 0;
	int            n_checks = 0;
	int            cyc = 0;
	bpi_brkind_type push_k [3] = '{BPI_BR_LINK_IMM, BPI_BLX_IMM, BPI_BLX_REG};
	bpi_brkind_type pop_k [4] = '{BPI_RET_LDM_SP, BPI_RET_LDR_SP, BPI_RET_BX_LR, BPI_RET_MOV_LR};

	bpi_ctrl i_bpi_ctrl (
		.sys_clk(sys_clk), .resetn(resetn), .fetch(fetch), .resolve_valid(resolve_valid),
		.resolve_va(resolve_va), .resolve_taken(resolve_taken), .ret_resolve(ret_resolve),
		.ret_actual(ret_actual), .prod(prod), .cons(cons), .cons_cond_fail(cons_cond_fail),
		.cons_multicycle(cons_multicycle), .passing_cycle_count(passing_cycle_count),
		.base_cycles(base_cycles), .flag_set(flag_set), .ls_busy(ls_busy),
		.predict_valid(predict_valid), .predict_taken(predict_taken),
		.predict_target(predict_target), .predict_from_issue(predict_from_issue),
		.branch_cost_reg(branch_cost_reg), .ret_mispredict_reg(ret_mispredict_reg),
		.stall(stall), .issue_cycles_reg(issue_cycles_reg),
		.flag_to_use_distance(flag_to_use_distance), .fwd_sel_reg(fwd_sel_reg),
		.alu_advance(alu_advance), .ls_advance(ls_advance)
	);

	// ----------------------------------------------------------------
	// clock and hang guard
	// ----------------------------------------------------------------
	always #5 sys_clk = ~sys_clk;

	// the whole run needs about a hundred cycles; far beyond that means a hang
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			bad_count++;
			stop_test;
		end
	end

	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic stop_test;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : stop_test

	task automatic fe(input bpi_brkind_type k, input logic c, input logic p,
		input logic [31:0] va, input logic [31:0] ln);
		@(posedge sys_clk);
		fetch <= '{1'b1, k, c, p, va, ln};
	endtask : fe

	// drops fetch, producer, consumer and both resolves; pulses last exactly one cycle this way
	task automatic idle;
		@(posedge sys_clk);
		fetch <= '0;
		prod <= '0;
		cons <= '0;
		resolve_valid <= 1'b0;
		ret_resolve <= 1'b0;
	endtask : idle

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_return;
		fe(BPI_BR_LINK_IMM, 1'b0, 1'b0, 32'h0000_1000, 32'h0000_1004);
		fe(BPI_RET_MOV_LR, 1'b0, 1'b0, 32'h0000_2000, 32'h0);
		@(negedge sys_clk);
		check("ret target", predict_target, 32'h0000_1004);
		check("ret issue", {predict_valid, predict_from_issue}, 2'h3);
		@(posedge sys_clk);
		fetch <= '0;
		ret_resolve <= 1'b1;
		ret_actual <= 32'h0000_1008;
		@(negedge sys_clk);
		check("ret cost", branch_cost_reg, BPI_COST_RET_OK);
		idle;
		@(negedge sys_clk);
		check("ret mispredict", ret_mispredict_reg, 1'b1);
		// fill with every push form, then pop with every pop form
		for (int i = 0; i < 3; i++)
			fe(push_k[i], 1'b0, 1'b0, 32'h100 * i, 32'h0000_4000 + 32'h10 * i);
		for (int i = 0; i < 4; i++) begin
			fe(pop_k[i], i == 0, 1'b0, 32'h0000_3000, 32'h0);
			@(negedge sys_clk);
			check("pop valid", predict_valid, i == 1 || i == 2);
			if (i == 1 || i == 2)
				check("pop target", predict_target, 32'h0000_4000 + 32'h10 * (2 - i));
		end
		@(posedge sys_clk);
		fetch <= '0;
		ret_resolve <= 1'b1;
		ret_actual <= 32'h0000_4000;
		idle;
		@(negedge sys_clk);
		check("ret match", ret_mispredict_reg, 1'b0);
	endtask : t_return

	task automatic t_branch;
		fe(BPI_BR_REG, 1'b0, 1'b0, 32'h0000_0048, 32'h0);
		@(negedge sys_clk);
		check("reg branch", predict_valid, 1'b0);
		fe(BPI_BR_IMM, 1'b0, 1'b0, 32'h0000_0048, 32'h0);
		@(negedge sys_clk);
		check("static", {predict_valid, predict_taken, predict_from_issue}, 3'h7);
		@(posedge sys_clk);
		fetch <= '0;
		resolve_valid <= 1'b1;
		resolve_taken <= 1'b1;
		resolve_va <= 32'h0000_0448;
		@(negedge sys_clk);
		check("static cost", branch_cost_reg, BPI_COST_STATIC);
		// up once, down twice to the floor, one taken must not flip it
		for (int i = 0; i < 4; i++) begin
			@(posedge sys_clk);
			resolve_valid <= 1'b0;
			fetch <= '{1'b1, BPI_BR_IMM, 1'b0, i[0], 32'h0000_0048, 32'h0};
			@(negedge sys_clk);
			check("dyn", {predict_valid, predict_taken, predict_from_issue},
				{1'b1, i == 0, 1'b0});
			@(posedge sys_clk);
			fetch <= '0;
			resolve_valid <= 1'b1;
			resolve_taken <= (i == 2);
			@(negedge sys_clk);
			check("dyn cost", branch_cost_reg, i[0] ? BPI_COST_FOLD : BPI_COST_DYN);
		end
		idle;
	endtask : t_branch

	task automatic t_lat(input logic [3:0] lat, input logic e, input logic l, input int exp,
		input logic [2:0] fw);
		int n;
		n = 0;
		@(posedge sys_clk);
		prod <= '{1'b1, 4'h1, 1'b1, lat, 4'he, 1'b0, 16'h0, 4'h0};
		ls_busy <= e;
		@(posedge sys_clk);
		prod <= '0;
		cons <= '{1'b1, 4'h1, 1'b1, e, l, 4'h7, 1'b1, 4'he, 1'b0};
		@(negedge sys_clk);
		check("ls advance", ls_advance, !e);
		while (stall === 1'b1 && n < 8) begin
			n++;
			@(negedge sys_clk);
		end
		check("stall cycles", n, exp);
		check("alu advance", alu_advance, 1'b1);
		idle;
		@(negedge sys_clk);
		check("fwd sel", fwd_sel_reg, fw);
	endtask : t_lat

	task automatic t_pair(input bpi_prod_type p, input bpi_cons_type c, input logic exp);
		@(posedge sys_clk);
		prod <= p;
		@(posedge sys_clk);
		prod <= '0;
		cons <= c;
		@(negedge sys_clk);
		check("pair stall", stall, exp);
		idle;
	endtask : t_pair

	task automatic t_fail(input int k, input logic m, input logic [3:0] pc, input logic [3:0] bc);
		logic [3:0] e;
		e = BPI_FAIL_BASE - 4'(k);
		if (e < BPI_FAIL_FLOOR)
			e = BPI_FAIL_FLOOR;
		if (pc < e)
			e = pc;
		if (!m)
			e = bc;
		@(posedge sys_clk);
		flag_set <= 1'b1;
		@(posedge sys_clk);
		flag_set <= 1'b0;
		repeat (k) @(posedge sys_clk);
		cons <= '{1'b1, 4'h0, 1'b0, 1'b0, 1'b0, 4'h9, 1'b1, 4'h0, 1'b0};
		cons_cond_fail <= 1'b1;
		cons_multicycle <= m;
		passing_cycle_count <= pc;
		base_cycles <= bc;
		idle;
		@(negedge sys_clk);
		check("fail cycles", issue_cycles_reg, e);
	endtask : t_fail

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		sys_clk = 1'b0;
		resetn = 1'b0;
		{resolve_valid, resolve_taken, ret_resolve, cons_cond_fail} = 4'h0;
		{cons_multicycle, flag_set, ls_busy} = 3'h0;
		{resolve_va, ret_actual, passing_cycle_count, base_cycles} = '0;
		fetch = '0;
		prod = '0;
		cons = '0;
		repeat (3) @(posedge sys_clk);
		resetn <= 1'b1;
		@(negedge sys_clk);
		check("reset regs", {branch_cost_reg, issue_cycles_reg, ret_mispredict_reg, fwd_sel_reg}, '0);
		t_return;
		t_branch;
		t_lat(4'h3, 1'b0, 1'b0, 2, 3'h1);
		t_lat(4'h3, 1'b1, 1'b0, 3, 3'h3);
		t_lat(4'h3, 1'b0, 1'b1, 1, 3'h2);
		t_lat(4'h1, 1'b0, 1'b0, 0, 3'h1);
		t_lat(4'h1, 1'b1, 1'b0, 1, 3'h3);
		t_pair('{1, 1, 1, 3, 0, 0, 0, 0}, '{1, 0, 0, 0, 0, 1, 1, 1, 0}, 1'b0);
		t_pair('{1, 1, 1, 3, 0, 0, 0, 0}, '{1, 0, 0, 0, 0, 1, 1, 1, 1}, 1'b1);
		t_pair('{1, 0, 0, 0, 14, 1, 16'h0020, 3}, '{1, 0, 0, 0, 0, 5, 1, 14, 0}, 1'b1);
		t_pair('{1, 0, 0, 0, 14, 1, 16'h0020, 3}, '{1, 0, 0, 0, 0, 6, 1, 14, 0}, 1'b0);
		for (int k = 0; k < 4; k++)
			t_fail(k, 1'b1, 4'h8, 4'h0);
		t_fail(0, 1'b1, 4'h2, 4'h0);
		t_fail(0, 1'b0, 4'h0, 4'h1);
		t_fail(1, 1'b0, 4'h0, 4'h2);
		stop_test;
	end

endmodule : tb_top
